// ---- rtl/ptcf_map.svh ----
`ifndef PTCF_MAP_SVH
`define PTCF_MAP_SVH

// Configuration byte offsets of the four registers
`define PTCF_OFS_HINT       8'h3f
`define PTCF_OFS_SLOT       8'h40
`define PTCF_OFS_CAPHDR     8'h80
`define PTCF_OFS_CAPS       8'h82

// Byte-lane positions inside the 32-bit read word
`define PTCF_HINT_LANE      24
`define PTCF_SLOT_LANE      0
`define PTCF_CAPHDR_LANE    0
`define PTCF_CAPS_LANE      16

// Interval hint
`define PTCF_HINT_RST       8'h04
`define PTCF_HINT_TIME_US   0.25
`define PTCF_CLK_PERIOD_NS  5.0

// Socket layout byte
`define PTCF_SLOT_RST       8'h20
`define PTCF_SLOT_RSVD7     7
`define PTCF_SLOT_RSVD3     3
`define PTCF_SLOT_CNT_HI    6
`define PTCF_SLOT_CNT_LO    4
`define PTCF_SLOT_CNT       3'h2
`define PTCF_SLOT_BAR       3'h0

// Feature list header
`define PTCF_NEXT_ITEM      8'h00
`define PTCF_KIND_CODE      8'h01

// Power capability word
`define PTCF_CAPS_RST       16'h7e02
`define PTCF_CAPS_WAKE_BIT  15
`define PTCF_WAKE_MASK      4'hf
`define PTCF_SPEC_REV       3'h2

`endif

// ---- rtl/ptcf_pkg.sv ----
package ptcf_pkg;

    // Register selected by a configuration access
    typedef enum logic [1:0] {
        RSEL_NONE = 2'b00,
        RSEL_HINT = 2'b01,
        RSEL_SLOT = 2'b10,
        RSEL_PM   = 2'b11
    } ptcf_rsel_t;

endpackage

// ---- rtl/ptcf_upd_if.sv ----
`timescale 1ns/1ps

// Update paths between the register front end and its two holders
interface ptcf_upd_if;
    logic        load_valid;
    logic [7:0]  load_data;
    logic [7:0]  hint;
    logic        wake_en;
    logic [15:0] caps;

    modport ctl       (output load_valid, output load_data, output wake_en,
                       input hint, input caps);
    modport hint_side (input load_valid, input load_data, output hint);
    modport caps_side (input wake_en, output caps);
endinterface

// ---- rtl/ptcf_hint_reg.sv ----
`timescale 1ns/1ps
`include "ptcf_map.svh"

module ptcf_hint_reg
    import ptcf_pkg::*;
(
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    ptcf_upd_if.hint_side upd
);

    logic [7:0] hint_r;

    // Only the serial loader may change the hint; host writes never reach here
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hint_r <= `PTCF_HINT_RST;
        end else if (upd.load_valid) begin
            hint_r <= upd.load_data;
        end
    end

    assign upd.hint = hint_r;

    a_hint_load: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        upd.load_valid |=> hint_r == $past(upd.load_data))
        else $error("hint did not take loaded value");

    a_hint_hold: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        !upd.load_valid |=> $stable(hint_r))
        else $error("hint changed without a load");

endmodule

// ---- rtl/ptcf_caps_reg.sv ----
`timescale 1ns/1ps
`include "ptcf_map.svh"

module ptcf_caps_reg
    import ptcf_pkg::*;
(
    input  wire logic mclk_in,
    input  wire logic rst_n_in,
    ptcf_upd_if.caps_side upd
);

    logic [15:0] caps_r;

    // Top bit tracks the wake enable; the rest stays at its reset pattern
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            caps_r <= `PTCF_CAPS_RST;
        end else begin
            caps_r <= {upd.wake_en, caps_r[`PTCF_CAPS_WAKE_BIT-1:0]};
        end
    end

    assign upd.caps = caps_r;

    a_wake_follow: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        $past(rst_n_in) |-> caps_r[`PTCF_CAPS_WAKE_BIT] == $past(upd.wake_en))
        else $error("wake bit does not follow enable");

    a_caps_fixed: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
        caps_r[`PTCF_CAPS_WAKE_BIT-1:0] == `PTCF_CAPS_RST)
        else $error("fixed capability bits changed");

endmodule

// ---- rtl/ptcf_config_tail.sv ----
`timescale 1ns/1ps
`include "ptcf_map.svh"

module ptcf_config_tail
    import ptcf_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        resetn_in,
    input  wire logic        cfg_req_in,
    input  wire logic        cfg_we_in,
    input  wire logic [7:0]  cfg_addr_in,
    input  wire logic [3:0]  cfg_be_in,
    input  wire logic [31:0] cfg_wdata_in,
    input  wire logic        eep_load_valid_in,
    input  wire logic [7:0]  eep_load_data_in,
    input  wire logic        unpowered_wake_enable_in,
    output logic             cfg_ack_out,
    output logic [31:0]      cfg_rdata_out,
    output logic [7:0]       bus_access_interval_hint_out,
    output logic             wake_from_unpowered_out,
    output logic             high_prio_out,
    output logic [7:0]       hint_gap_cyc_out
);

    // Cycles per shortest access gap; longest time, so round down
    localparam int unsigned HINT_GAP_CYC =
        int'($floor(`PTCF_HINT_TIME_US * 1000.0 / `PTCF_CLK_PERIOD_NS));
    localparam logic [7:0]  HINT_GAP_CYC8 = HINT_GAP_CYC[7:0];
    // Dword numbers of the decoded words, and the capability reset image
    localparam logic [5:0]  DW_HINT       = 6'(`PTCF_OFS_HINT >> 2);
    localparam logic [5:0]  DW_SLOT       = 6'(`PTCF_OFS_SLOT >> 2);
    localparam logic [5:0]  DW_PM         = 6'(`PTCF_OFS_CAPHDR >> 2);
    localparam logic [15:0] CAPS_RST      = `PTCF_CAPS_RST;

    logic        rst_meta_n_r;
    logic        rst_sync_n_r;
    logic        cfg_ack_r;
    logic [31:0] cfg_rdata_r;
    logic [31:0] rdata_nxt;
    logic        high_prio_r;
    logic [7:0]  gap_cyc_r;
    ptcf_rsel_t  rsel;
    logic [7:0]  slot_byte;
    logic [15:0] caphdr_word;

    ptcf_upd_if upd ();

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_meta_n_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_n_r <= 1'b1;
            rst_sync_n_r <= rst_meta_n_r;
        end
    end

    // Loader and wake enable come from same-clock logic, no synchroniser
    assign upd.load_valid = eep_load_valid_in;
    assign upd.load_data  = eep_load_data_in;
    assign upd.wake_en    = unpowered_wake_enable_in;

    ptcf_hint_reg i_ptcf_hint_reg (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_sync_n_r),
        .upd      (upd.hint_side)
    );

    ptcf_caps_reg i_ptcf_caps_reg (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_sync_n_r),
        .upd      (upd.caps_side)
    );

    // Hardwired bytes; nothing in the design can alter them
    assign slot_byte   = `PTCF_SLOT_RST;
    assign caphdr_word = {`PTCF_NEXT_ITEM, `PTCF_KIND_CODE};

    // Dword decode; neighbours' bytes in a shared dword read as zero here
    always_comb begin
        if (cfg_addr_in[7:2] == DW_HINT) begin
            rsel = RSEL_HINT;
        end else if (cfg_addr_in[7:2] == DW_SLOT) begin
            rsel = RSEL_SLOT;
        end else if (cfg_addr_in[7:2] == DW_PM) begin
            rsel = RSEL_PM;
        end else begin
            rsel = RSEL_NONE;
        end
    end

    // Read word assembly; writes return zero data
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (!cfg_we_in) begin
            case (rsel)
                RSEL_HINT: begin
                    rdata_nxt[`PTCF_HINT_LANE +: 8] = upd.hint;
                end
                RSEL_SLOT: begin
                    rdata_nxt[`PTCF_SLOT_LANE +: 8] = slot_byte;
                end
                RSEL_PM: begin
                    rdata_nxt[`PTCF_CAPHDR_LANE +: 16] = caphdr_word;
                    rdata_nxt[`PTCF_CAPS_LANE +: 16]   = upd.caps;
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // Every request is answered one cycle later, read or write alike
    always_ff @(posedge mclk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            cfg_ack_r <= 1'b0;
        end else begin
            cfg_ack_r <= cfg_req_in;
        end
    end

    // Read data; a write only acknowledges, no state is touched
    always_ff @(posedge mclk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            cfg_rdata_r <= 32'h0000_0000;
        end else if (cfg_req_in) begin
            cfg_rdata_r <= rdata_nxt;
        end else begin
            cfg_rdata_r <= 32'h0000_0000;
        end
    end

    // Arbitration hint decode: default value asks for the tightest slot
    always_ff @(posedge mclk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            high_prio_r <= 1'b0;
            gap_cyc_r   <= 8'h00;
        end else begin
            high_prio_r <= (upd.hint == `PTCF_HINT_RST);
            gap_cyc_r   <= (upd.hint == `PTCF_HINT_RST) ? HINT_GAP_CYC8 : 8'h00;
        end
    end

    assign cfg_ack_out                  = cfg_ack_r;
    assign cfg_rdata_out                = cfg_rdata_r;
    assign bus_access_interval_hint_out = upd.hint; // Flop inside the holder
    assign wake_from_unpowered_out      = upd.caps[`PTCF_CAPS_WAKE_BIT];
    assign high_prio_out                = high_prio_r;
    assign hint_gap_cyc_out             = gap_cyc_r;

    // Helper decode for the checks below
    logic cfg_rd_hit_hint;
    logic cfg_rd_hit_slot;
    logic cfg_rd_hit_pm;
    logic cfg_wr_any;

    assign cfg_rd_hit_hint = cfg_req_in && !cfg_we_in && rsel == RSEL_HINT;
    assign cfg_rd_hit_slot = cfg_req_in && !cfg_we_in && rsel == RSEL_SLOT;
    assign cfg_rd_hit_pm   = cfg_req_in && !cfg_we_in && rsel == RSEL_PM;
    assign cfg_wr_any      = cfg_req_in && cfg_we_in && |cfg_be_in && |cfg_wdata_in;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_sync_n_r);

    // Request taken, answer exactly one cycle later, then the acknowledge follows the request of the cycle before
    sequence s_req;
        cfg_req_in;
    endsequence

    sequence s_ack_once;
        cfg_ack_out ##1 (cfg_ack_out == $past(cfg_req_in));
    endsequence

    a_ack_timing: assert property (s_req |=> s_ack_once)
        else $error("request not acknowledged after one cycle");

    a_ack_cause: assert property (cfg_ack_out |-> $past(cfg_req_in))
        else $error("acknowledge without a request");

    // Reset release: hint, wake bit and priority decode come out at their reset values
    sequence s_rst_release;
        $rose(rst_sync_n_r);
    endsequence

    a_hint_rst: assert property (s_rst_release |->
        bus_access_interval_hint_out == `PTCF_HINT_RST)
        else $error("hint not at default after reset");

    a_wake_rst: assert property (s_rst_release |->
        !wake_from_unpowered_out)
        else $error("wake bit set after reset");

    a_prio_rst: assert property (s_rst_release |->
        !high_prio_out && hint_gap_cyc_out == 8'h00)
        else $error("priority decode not cleared by reset");

    // Read data stands only with the acknowledge
    a_rdata_idle: assert property (!cfg_ack_out |->
        cfg_rdata_out == 32'h0000_0000)
        else $error("read data without acknowledge");

    a_wr_zero: assert property (cfg_req_in && cfg_we_in |=>
        cfg_rdata_out == 32'h0000_0000)
        else $error("write returned data");

    a_unmapped_zero: assert property (cfg_req_in && rsel == RSEL_NONE |=>
        cfg_rdata_out == 32'h0000_0000)
        else $error("unmapped dword returned data");

    // Hint read returns the live hint in the top lane
    sequence s_hint_read;
        cfg_rd_hit_hint && !eep_load_valid_in;
    endsequence

    a_hint_readback: assert property (s_hint_read |=>
        cfg_rdata_out[`PTCF_HINT_LANE +: 8] == bus_access_interval_hint_out &&
        cfg_rdata_out[`PTCF_HINT_LANE-1:0] == 24'h00_0000)
        else $error("hint read returned wrong value");

    // Priority flag and gap count derive from the hint with one cycle lag;
    // the first edge after reset release still shows the reset values
    a_prio_flag: assert property ($past(rst_sync_n_r) |->
        high_prio_out == ($past(bus_access_interval_hint_out) == `PTCF_HINT_RST) &&
        hint_gap_cyc_out == (high_prio_out ? HINT_GAP_CYC8 : 8'h00))
        else $error("priority hint decode wrong");

    // Socket layout fields
    a_slot_rsvd: assert property (cfg_rd_hit_slot |=>
        !cfg_rdata_out[`PTCF_SLOT_RSVD7] && !cfg_rdata_out[`PTCF_SLOT_RSVD3])
        else $error("reserved socket bit set");

    a_slot_count: assert property (cfg_rd_hit_slot |=>
        cfg_rdata_out[`PTCF_SLOT_CNT_HI:`PTCF_SLOT_CNT_LO] == `PTCF_SLOT_CNT)
        else $error("socket count wrong");

    a_slot_window: assert property (cfg_rd_hit_slot |=>
        cfg_rdata_out[2:0] == `PTCF_SLOT_BAR && cfg_rdata_out[31:8] == 24'h00_0000)
        else $error("first window field wrong");

    a_slot_word: assert property (cfg_rd_hit_slot |=>
        cfg_rdata_out[7:0] == `PTCF_SLOT_RST)
        else $error("socket layout byte wrong");

    // Feature list header fields
    a_next_item: assert property (cfg_rd_hit_pm |=>
        cfg_rdata_out[15:8] == `PTCF_NEXT_ITEM)
        else $error("next item pointer not zero");

    a_kind_code: assert property (cfg_rd_hit_pm |=>
        cfg_rdata_out[7:0] == `PTCF_KIND_CODE)
        else $error("feature kind code wrong");

    // Capability word, its wake bit and fixed fields
    sequence s_pm_read;
        cfg_rd_hit_pm ##0 unpowered_wake_enable_in == wake_from_unpowered_out;
    endsequence

    a_caps_read: assert property (s_pm_read |=>
        cfg_rdata_out[31:16] ==
        {$past(unpowered_wake_enable_in), CAPS_RST[14:0]})
        else $error("capability word read wrong");

    a_caps_middle: assert property (cfg_rd_hit_pm |=>
        cfg_rdata_out[26:19] == CAPS_RST[10:3])
        else $error("fixed capability bits wrong");

    a_wake_pin: assert property (
        unpowered_wake_enable_in ##1 unpowered_wake_enable_in |->
        wake_from_unpowered_out)
        else $error("wake capability not advertised");

    a_wake_mask: assert property (cfg_rd_hit_pm |=>
        cfg_rdata_out[30:27] == `PTCF_WAKE_MASK)
        else $error("wake state mask wrong");

    a_spec_rev: assert property (cfg_rd_hit_pm |=>
        cfg_rdata_out[18:16] == `PTCF_SPEC_REV)
        else $error("power spec revision wrong");

    // A write never moves a stored value
    sequence s_write_quiet;
        cfg_wr_any && !eep_load_valid_in;
    endsequence

    a_write_ignored: assert property (s_write_quiet |=>
        $stable(bus_access_interval_hint_out) && cfg_rdata_out == 32'h0000_0000)
        else $error("write altered register state");

    a_write_caps: assert property (cfg_wr_any ##0
        $stable(unpowered_wake_enable_in) |=> $stable(wake_from_unpowered_out))
        else $error("write altered capability word");

endmodule

// ---- sim/test_ptcf_config_tail.sv ----
`timescale 1ns/1ps

// One compare: counts it and reports a difference at once
`define chk(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("mismatch t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end

module test_ptcf_config_tail;
    import ptcf_pkg::*;

    logic        mclk_in;
    logic        resetn_in;
    logic        cfg_req_in;
    logic        cfg_we_in;
    logic [7:0]  cfg_addr_in;
    logic [3:0]  cfg_be_in;
    logic [31:0] cfg_wdata_in;
    logic        eep_load_valid_in;
    logic [7:0]  eep_load_data_in;
    logic        unpowered_wake_enable_in;
    logic        cfg_ack_out;
    logic [31:0] cfg_rdata_out;
    logic [7:0]  bus_access_interval_hint_out;
    logic        wake_from_unpowered_out;
    logic        high_prio_out;
    logic [7:0]  hint_gap_cyc_out;
    int          fails;
    int          compares;
    int          cycles;

    ptcf_config_tail i_ptcf_config_tail (
        .mclk_in                      (mclk_in),
        .resetn_in                    (resetn_in),
        .cfg_req_in                   (cfg_req_in),
        .cfg_we_in                    (cfg_we_in),
        .cfg_addr_in                  (cfg_addr_in),
        .cfg_be_in                    (cfg_be_in),
        .cfg_wdata_in                 (cfg_wdata_in),
        .eep_load_valid_in            (eep_load_valid_in),
        .eep_load_data_in             (eep_load_data_in),
        .unpowered_wake_enable_in     (unpowered_wake_enable_in),
        .cfg_ack_out                  (cfg_ack_out),
        .cfg_rdata_out                (cfg_rdata_out),
        .bus_access_interval_hint_out (bus_access_interval_hint_out),
        .wake_from_unpowered_out      (wake_from_unpowered_out),
        .high_prio_out                (high_prio_out),
        .hint_gap_cyc_out             (hint_gap_cyc_out)
    );

    // 200 MHz clock
    initial mclk_in = 1'b0;
    always #2.5 mclk_in = ~mclk_in;

    // Hang guard: the whole run needs under a hundred cycles
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Reset for 10 cycles, then wait past the two-flop release
    task automatic do_reset();
        resetn_in = 1'b0;
        repeat (10) @(negedge mclk_in);
        resetn_in = 1'b1;
        repeat (4) @(negedge mclk_in);
    endtask

    // One config access; ack is expected at the first cycle after the taken edge
    task automatic cfg_access(input logic we, input logic [7:0] addr,
                              input logic [31:0] exp);
        int lat;
        lat = -1;
        cfg_req_in   = 1'b1;
        cfg_we_in    = we;
        cfg_addr_in  = addr;
        cfg_be_in    = 4'hf;
        cfg_wdata_in = 32'hffff_ffff;
        for (int i = 0; i < 4 && lat < 0; i++) begin
            @(negedge mclk_in);
            cfg_req_in = 1'b0;
            if (cfg_ack_out === 1'b1) begin
                lat = i;
                `chk(cfg_rdata_out, exp)
            end
        end
        `chk(lat, 0)
        // Idle cycle so the next request never re-raises req in this step
        @(negedge mclk_in);
    endtask

    // Loader strobe of one byte; stays up so loads can run back to back
    task automatic eep_load(input logic [7:0] data);
        eep_load_valid_in = 1'b1;
        eep_load_data_in  = data;
        @(negedge mclk_in);
    endtask

    // Loader strobe released after the last byte
    task automatic eep_stop();
        eep_load_valid_in = 1'b0;
        eep_load_data_in  = 8'h00;
    endtask

    // Values straight after reset
    task automatic t_reset_values();
        `chk(bus_access_interval_hint_out, 8'h04)
        `chk(high_prio_out, 1'b1)
        `chk(hint_gap_cyc_out, 8'h32)
        `chk(wake_from_unpowered_out, 1'b0)
        `chk(cfg_ack_out, 1'b0)
        `chk(cfg_rdata_out, 32'h0000_0000)
    endtask

    // Reads of every mapped dword and of unmapped ones
    task automatic t_reads();
        cfg_access(1'b0, 8'h3c, 32'h0400_0000);
        cfg_access(1'b0, 8'h40, 32'h0000_0020);
        cfg_access(1'b0, 8'h80, 32'h7e02_0001);
        cfg_access(1'b0, 8'h44, 32'h0000_0000);
        cfg_access(1'b0, 8'hfc, 32'h0000_0000);
    endtask

    // Host writes of all ones must change nothing
    task automatic t_writes();
        cfg_access(1'b1, 8'h3c, 32'h0000_0000);
        cfg_access(1'b1, 8'h40, 32'h0000_0000);
        cfg_access(1'b1, 8'h80, 32'h0000_0000);
        `chk(bus_access_interval_hint_out, 8'h04)
        cfg_access(1'b0, 8'h3c, 32'h0400_0000);
        cfg_access(1'b0, 8'h40, 32'h0000_0020);
        cfg_access(1'b0, 8'h80, 32'h7e02_0001);
    endtask

    // Loader overwrites the hint, back to back, then restores the default
    task automatic t_loader();
        eep_load(8'h10);
        eep_load(8'hff);
        eep_stop();
        @(negedge mclk_in);
        `chk(bus_access_interval_hint_out, 8'hff)
        `chk(high_prio_out, 1'b0)
        `chk(hint_gap_cyc_out, 8'h00)
        cfg_access(1'b0, 8'h3c, 32'hff00_0000);
        eep_load(8'h04);
        eep_stop();
        repeat (2) @(negedge mclk_in);
        `chk(high_prio_out, 1'b1)
        `chk(hint_gap_cyc_out, 8'h32)
    endtask

    // Wake enable drives capability bit 15 only
    task automatic t_wake();
        unpowered_wake_enable_in = 1'b1;
        @(negedge mclk_in);
        `chk(wake_from_unpowered_out, 1'b1)
        cfg_access(1'b0, 8'h80, 32'hfe02_0001);
        cfg_access(1'b1, 8'h80, 32'h0000_0000);
        cfg_access(1'b0, 8'h80, 32'hfe02_0001);
        unpowered_wake_enable_in = 1'b0;
        @(negedge mclk_in);
        `chk(wake_from_unpowered_out, 1'b0)
        cfg_access(1'b0, 8'h80, 32'h7e02_0001);
    endtask

    // Reset in mid-run brings a loaded hint back to its default
    task automatic t_mid_reset();
        eep_load(8'h33);
        eep_stop();
        unpowered_wake_enable_in = 1'b1;
        @(negedge mclk_in);
        `chk(bus_access_interval_hint_out, 8'h33)
        unpowered_wake_enable_in = 1'b0;
        do_reset();
        `chk(bus_access_interval_hint_out, 8'h04)
        `chk(wake_from_unpowered_out, 1'b0)
        cfg_access(1'b0, 8'h80, 32'h7e02_0001);
    endtask

    // Main sequence, inputs change on falling edges only
    initial begin
        fails                    = 0;
        compares                 = 0;
        cycles                   = 0;
        cfg_req_in               = 1'b0;
        cfg_we_in                = 1'b0;
        cfg_addr_in              = 8'h00;
        cfg_be_in                = 4'h0;
        cfg_wdata_in             = 32'h0000_0000;
        eep_load_valid_in        = 1'b0;
        eep_load_data_in         = 8'h00;
        unpowered_wake_enable_in = 1'b0;
        resetn_in                = 1'b0;
        @(negedge mclk_in);
        do_reset();
        t_reset_values();
        t_reads();
        t_writes();
        t_loader();
        t_wake();
        t_mid_reset();
        end_sim();
    end
endmodule
